// >>> hw/flash_host_pkg.sv
// Shared constants and types for the flash command host.
// Assumes a 10 MHz single clock and a 16-bit command path to the flash.
package flash_host_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 23;
	localparam int DATA_W = 16;

	// ----------------------------------------------------------------
	// Software register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_BASE   = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_RDATA  = 8'h14;

	// Command register field and status register bit positions.
	localparam int CMD_OP_LSB        = 0;
	localparam int STAT_BUSY         = 0;
	localparam int STAT_SECURED      = 1;
	localparam int STAT_DROPPED      = 2;
	localparam int STAT_ABORT        = 3;
	localparam int STAT_TIMEOUT      = 4;
	localparam int STAT_LOCK_SECURED = 5;
	localparam int STAT_LOCK_PERSIST = 6;
	localparam int STAT_LOCK_PASSWD  = 7;

	// ----------------------------------------------------------------
	// Flash data line meanings
	// ----------------------------------------------------------------
	localparam int DQ_ABORT_BIT      = 1;
	localparam int DQ_TIMEOUT_BIT    = 5;
	localparam int LOCK_SECURED_BIT  = 0;
	localparam int LOCK_PERSIST_BIT  = 1;
	localparam int LOCK_PASSWD_BIT   = 2;

	// ----------------------------------------------------------------
	// Command cycle addresses and data
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 23'h000555;
	localparam logic [DATA_W-1:0] UNLOCK1_DATA = 16'h00aa;
	localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 23'h0002aa;
	localparam logic [DATA_W-1:0] UNLOCK2_DATA = 16'h0055;
	localparam logic [DATA_W-1:0] SECURED_DATA = 16'h0088;
	localparam logic [ADDR_W-1:0] EXIT_ADDR    = 23'h000000;
	localparam logic [DATA_W-1:0] EXIT_DATA    = 16'h0000;
	localparam logic [ADDR_W-1:0] RESET_ADDR   = 23'h000000;
	localparam logic [DATA_W-1:0] RESET_DATA   = 16'h00f0;

	// Secured region word ranges.
	localparam logic [ADDR_W-1:0] SERIAL_LAST   = 23'h000007;
	localparam logic [ADDR_W-1:0] CUSTOMER_LAST = 23'h00007f;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ      = 10;
	localparam int WR_PULSE_NS  = 100;
	localparam int WR_HOLD_NS   = 100;
	localparam int RD_ACCESS_NS = 200;
	localparam int SYNC_LAT     = 3;
	localparam int WR_PULSE_CYC = (WR_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int WR_HOLD_CYC  = (WR_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int RD_WAIT_CYC  =
		(RD_ACCESS_NS * CLK_MHZ + 999) / 1000 + SYNC_LAT;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NONE    = 3'b000,
		OP_RESET   = 3'b001,
		OP_ENTRY   = 3'b010,
		OP_PROGRAM = 3'b011,
		OP_EXIT    = 3'b100,
		OP_READ    = 3'b101
	} op_type;

	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_SETUP  = 3'b001,
		S_STROBE = 3'b010,
		S_HOLD   = 3'b011,
		S_READ   = 3'b100
	} state_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq;
		logic              dq_oe;
		logic              ce_n;
		logic              we_n;
		logic              oe_n;
	} flash_pins_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} bus_cycle_type;

endpackage : flash_host_pkg

// >>> hw/dq_input_sync.sv
// Three-stage synchroniser for the flash data lines.
// Assumes the data lines change asynchronously to i_clk.
`timescale 1ns/1ps
module dq_input_sync
	import flash_host_pkg::*;
(
	input  wire logic              i_clk,   // System clock.
	input  wire logic              i_rstn,  // Async reset, active low.
	input  wire logic [DATA_W-1:0] i_dq,    // Raw data lines.
	output logic      [DATA_W-1:0] o_dq     // Filtered data lines.
);

	// ----------------------------------------------------------------
	// Per-bit stages
	// ----------------------------------------------------------------
	genvar b;
	generate
		for (b = 0; b < DATA_W; b++)
		begin : g_bit
			logic meta;
			logic stage2;
			logic stage3;

			// The first stage feeds only the second; a bit counts once
			// the second and third stages agree, which rejects glitches.
			always_ff @(posedge i_clk or negedge i_rstn)
			begin
				if (!i_rstn)
				begin
					meta    <= 1'b0;
					stage2  <= 1'b0;
					stage3  <= 1'b0;
					o_dq[b] <= 1'b0;
				end
				else
				begin
					meta   <= i_dq[b];
					stage2 <= meta;
					stage3 <= stage2;
					if (stage2 == stage3)
						o_dq[b] <= stage3;
				end
			end
		end
	endgenerate

endmodule : dq_input_sync

// >>> hw/flash_cmd_host.sv
// Host controller that issues command sequences to a parallel flash.
// Assumes software on a simple strobe port and one flash on the pins.
//
// What this block does
// - One write of 00F0h anywhere in the base region is software reset.
// - Entry is AAh at 555h, 55h at 2AAh, 88h at 555h.
// - Program is the two unlocks, 88h at 555h, then data at the word.
// - Exit is the two unlocks, 88h at 555h, then 0000h at base+000h.
`timescale 1ns/1ps
module flash_cmd_host
	import flash_host_pkg::*;
(
	input  wire logic              i_clk,    // System clock, 10 MHz.
	input  wire logic              i_rstn,   // Async reset, active low.
	input  wire logic [7:0]        i_addr,   // Register byte address.
	input  wire logic [31:0]       i_wdata,  // Register write data.
	input  wire logic              i_wr,     // Register write strobe.
	input  wire logic              i_rd,     // Register read strobe.
	output logic      [31:0]       o_rdata,  // Read data, one cycle later.
	output flash_pins_type         o_pin,    // Flash address and controls.
	input  wire logic [DATA_W-1:0] i_dq      // Flash data lines in.
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	state_type         state;
	op_type            op;
	logic [1:0]        step;
	logic [3:0]        cnt;
	logic [ADDR_W-1:0] target;
	logic [DATA_W-1:0] wdata;
	logic [ADDR_W-1:0] base;
	logic [DATA_W-1:0] rdata;
	logic              secured;
	logic              dropped;
	logic              abort_status_flag;
	logic              timeout_status_flag;
	logic [DATA_W-1:0] dq_sync;
	bus_cycle_type     cyc;
	op_type            req_op;
	logic              req;
	logic              req_ok;
	logic              last_step;

	dq_input_sync dq_input_sync_i (
		.i_clk  (i_clk),
		.i_rstn (i_rstn),
		.i_dq   (i_dq),
		.o_dq   (dq_sync)
	);

	// ----------------------------------------------------------------
	// Command sequence tables
	// ----------------------------------------------------------------

	// Address and data of each bus cycle of each operation.
	function automatic bus_cycle_type cycle_of(
		input op_type            f_op,
		input logic [1:0]        f_step,
		input logic [ADDR_W-1:0] f_base,
		input logic [ADDR_W-1:0] f_target,
		input logic [DATA_W-1:0] f_data
	);
		bus_cycle_type c;
		c.addr = f_target;
		c.data = f_data;
		if (f_op == OP_RESET)
		begin
			c.addr = f_base + RESET_ADDR;
			c.data = RESET_DATA;
		end
		else if (f_op != OP_READ)
		begin
			unique case (f_step)
				2'd0:
				begin
					c.addr = f_base + UNLOCK1_ADDR;
					c.data = UNLOCK1_DATA;
				end
				2'd1:
				begin
					c.addr = f_base + UNLOCK2_ADDR;
					c.data = UNLOCK2_DATA;
				end
				2'd2:
				begin
					c.addr = f_base + UNLOCK1_ADDR;
					c.data = SECURED_DATA;
				end
				2'd3:
				begin
					if (f_op == OP_EXIT)
					begin
						c.addr = f_base + EXIT_ADDR;
						c.data = EXIT_DATA;
					end
				end
			endcase
		end
		return c;
	endfunction : cycle_of

	// Index of the final bus cycle of each operation.
	function automatic logic [1:0] final_step(input op_type f_op);
		logic [1:0] s;
		unique case (f_op)
			OP_ENTRY:   s = 2'd2;
			OP_PROGRAM: s = 2'd3;
			OP_EXIT:    s = 2'd3;
			default:    s = 2'd0;
		endcase
		return s;
	endfunction : final_step

	assign cyc       = cycle_of(op, step, base, target, wdata);
	assign last_step = (step == final_step(op));
	assign req_op    = op_type'(i_wdata[CMD_OP_LSB +: 3]);
	assign req       = i_wr && (i_addr == REG_CMD);

	// A secured program is refused outside the 128-word region, so a
	// stray target never lands in the main array by mistake.
	assign req_ok = (state == S_IDLE) && (req_op != OP_NONE)
		&& (req_op <= OP_READ)
		&& !(req_op == OP_PROGRAM && target > CUSTOMER_LAST);

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------

	// Parameter registers; they may change at any time, but a running
	// sequence reads them each cycle, so software waits for idle.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			target <= '0;
			wdata  <= '0;
			base   <= '0;
		end
		else if (i_wr)
		begin
			if (i_addr == REG_ADDR)
				target <= i_wdata[ADDR_W-1:0];
			if (i_addr == REG_WDATA)
				wdata <= i_wdata[DATA_W-1:0];
			if (i_addr == REG_BASE)
				base <= i_wdata[ADDR_W-1:0];
		end
	end

	// A refused command leaves a sticky mark until the next accepted one.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			dropped <= 1'b0;
		else if (req)
			dropped <= !req_ok;
	end

	// Read data stand in the cycle after the strobe; unmapped reads zero.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_rdata <= '0;
		else if (i_rd)
		begin
			o_rdata <= '0;
			unique case (i_addr)
				REG_ADDR:  o_rdata <= {9'h000, target};
				REG_WDATA: o_rdata <= {16'h0000, wdata};
				REG_BASE:  o_rdata <= {9'h000, base};
				REG_RDATA: o_rdata <= {16'h0000, rdata};
				REG_STATUS:
				begin
					o_rdata[STAT_BUSY]         <= (state != S_IDLE);
					o_rdata[STAT_SECURED]      <= secured;
					o_rdata[STAT_DROPPED]      <= dropped;
					o_rdata[STAT_ABORT]        <= abort_status_flag;
					o_rdata[STAT_TIMEOUT]      <= timeout_status_flag;
					o_rdata[STAT_LOCK_SECURED] <= rdata[LOCK_SECURED_BIT];
					o_rdata[STAT_LOCK_PERSIST] <= rdata[LOCK_PERSIST_BIT];
					o_rdata[STAT_LOCK_PASSWD]  <= rdata[LOCK_PASSWD_BIT];
				end
				default:   o_rdata <= '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Bus cycle sequencer
	// ----------------------------------------------------------------

	// Each write cycle is setup, strobe and hold; a read waits out the
	// access time plus the synchroniser latency before sampling.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state <= S_IDLE;
			op    <= OP_NONE;
			step  <= 2'd0;
			cnt   <= 4'h0;
		end
		else
		begin
			unique case (state)
				S_IDLE:
				begin
					if (req && req_ok)
					begin
						op    <= req_op;
						step  <= 2'd0;
						state <= S_SETUP;
					end
				end
				S_SETUP:
				begin
					if (op == OP_READ)
					begin
						cnt   <= 4'(RD_WAIT_CYC - 1);
						state <= S_READ;
					end
					else
					begin
						cnt   <= 4'(WR_PULSE_CYC - 1);
						state <= S_STROBE;
					end
				end
				S_STROBE:
				begin
					if (cnt == 4'h0)
					begin
						cnt   <= 4'(WR_HOLD_CYC - 1);
						state <= S_HOLD;
					end
					else
						cnt <= cnt - 4'h1;
				end
				S_HOLD:
				begin
					if (cnt != 4'h0)
						cnt <= cnt - 4'h1;
					else if (last_step)
					begin
						op    <= OP_NONE;
						state <= S_IDLE;
					end
					else
					begin
						step  <= step + 2'd1;
						state <= S_SETUP;
					end
				end
				S_READ:
				begin
					if (cnt == 4'h0)
					begin
						op    <= OP_NONE;
						state <= S_IDLE;
					end
					else
						cnt <= cnt - 4'h1;
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// Pins: data are driven only while output enable is off, so the
	// host and the flash never fight over the data lines.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_pin <= '{addr: '0, dq: '0, dq_oe: 1'b0, ce_n: 1'b1,
				we_n: 1'b1, oe_n: 1'b1};
		else
		begin
			o_pin.addr  <= cyc.addr;
			o_pin.dq    <= cyc.data;
			o_pin.dq_oe <= (op != OP_NONE) && (op != OP_READ);
			o_pin.ce_n  <= (op == OP_NONE);
			o_pin.we_n  <= !(state == S_SETUP && op != OP_READ)
				&& !(state == S_STROBE && cnt != 4'h0);
			o_pin.oe_n  <= (op != OP_READ);
		end
	end

	// ----------------------------------------------------------------
	// Flash state seen by the host
	// ----------------------------------------------------------------

	// Read word capture; status flags are taken from every read so that
	// a status poll needs no command of its own.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			rdata               <= '0;
			abort_status_flag   <= 1'b0;
			timeout_status_flag <= 1'b0;
		end
		else if (state == S_READ && cnt == 4'h0)
		begin
			rdata               <= dq_sync;
			abort_status_flag   <= dq_sync[DQ_ABORT_BIT];
			timeout_status_flag <= dq_sync[DQ_TIMEOUT_BIT];
		end
	end

	// Secured mapping follows the last completed entry, exit or reset.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			secured <= 1'b0;
		else if (state == S_HOLD && cnt == 4'h0 && last_step)
		begin
			if (op == OP_ENTRY)
				secured <= 1'b1;
			else if (op == OP_EXIT)
				secured <= 1'b0;
			else if (op == OP_RESET)
				secured <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_reset_cycle: assert property (@(posedge i_clk) disable iff (!i_rstn)
		$fell(o_pin.we_n) && op == OP_RESET |->
			o_pin.dq == RESET_DATA && o_pin.addr == 23'(base + RESET_ADDR))
		else $error("Reset write carries wrong address or data.");

	a_entry_first: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state == S_SETUP && op == OP_ENTRY && step == 2'd0 |=> ##1
			o_pin.addr == 23'(base + UNLOCK1_ADDR) && o_pin.dq == UNLOCK1_DATA)
		else $error("Entry sequence does not open with the first unlock.");

	a_entry_maps: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state == S_HOLD && cnt == 4'h0 && last_step && op == OP_ENTRY
			|=> secured && state == S_IDLE)
		else $error("Secured mapping not set after entry.");

	a_prog_setup: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state == S_STROBE && op == OP_PROGRAM && step == 2'd2 |->
			o_pin.dq == SECURED_DATA && !o_pin.we_n)
		else $error("Program setup cycle is wrong.");

	a_prog_target: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state == S_STROBE && op == OP_PROGRAM && step == 2'd3 |->
			o_pin.addr == target && o_pin.dq == wdata)
		else $error("Program data cycle misses the target word.");

	a_exit_final: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state == S_HOLD && op == OP_EXIT && last_step |->
			o_pin.addr == base && o_pin.dq == EXIT_DATA)
		else $error("Exit closing cycle is wrong.");

	a_exit_unmaps: assert property (@(posedge i_clk) disable iff (!i_rstn)
		$fell(secured) |-> $past(op) == OP_EXIT || $past(op) == OP_RESET)
		else $error("Secured mapping dropped without exit or reset.");

	a_no_contention: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_pin.dq_oe |-> o_pin.oe_n ##1 (o_pin.dq_oe || o_pin.oe_n || o_pin.ce_n))
		else $error("Host drives data while the flash may drive.");

	a_we_pulse: assert property (@(posedge i_clk) disable iff (!i_rstn)
		$fell(o_pin.we_n) |-> !o_pin.ce_n ##1 o_pin.we_n [*2])
		else $error("Write strobe width or hold is wrong.");

endmodule : flash_cmd_host

// >>> verification/flash_dev_model.sv
// Behavioural model of the flash as seen on the host's pins.
// Assumes the bench resolves the data wire and gives the base address.
`timescale 1ns/1ps
module flash_dev_model
	import flash_host_pkg::*;
(
	input  wire flash_pins_type    i_pin,      // Host pins.
	input  wire logic [DATA_W-1:0] i_dq,       // Resolved data wire.
	input  wire logic [ADDR_W-1:0] i_base,     // Command base address.
	input  wire logic              i_ovr,      // Return the status word.
	input  wire logic [DATA_W-1:0] i_ovr_word, // Status or lock word.
	output logic      [DATA_W-1:0] o_dq        // Data driven by the flash.
);
	// ------------------------------------------------------------
	// Command interpreter
	// ------------------------------------------------------------
	logic [DATA_W-1:0] sec [0:127];
	logic [ADDR_W-1:0] log_addr [0:63];
	logic [DATA_W-1:0] log_data [0:63];
	logic [ADDR_W-1:0] off;
	logic [DATA_W-1:0] word;
	logic              secured;
	logic              volatile_sector_lock;
	logic              persistent_sector_lock;
	logic              persistent_lock_freeze;
	int                wn;
	int                step;

	// Secured words start with a known pattern so reads can be checked.
	initial
	begin
		wn = 0;
		step = 0;
		secured = 1'b0;
		volatile_sector_lock = 1'b1;
		persistent_sector_lock = 1'b1;
		persistent_lock_freeze = 1'b1;
		for (int i = 0; i < 128; i++)
			sec[i] = 16'h5a00 + 16'(i);
	end

	// Each write cycle is taken as write enable rises with the chip on.
	always @(posedge i_pin.we_n)
	begin
		if (!i_pin.ce_n)
		begin
			off = i_pin.addr - i_base;
			log_addr[wn] = i_pin.addr;
			log_data[wn] = i_dq;
			wn++;
			if (i_dq == 16'h00f0)
			begin
				step = 0;
				secured = 1'b0;
			end
			else if (step == 0 && off == 23'h555 && i_dq == 16'h00aa)
				step = 1;
			else if (step == 1 && off == 23'h2aa && i_dq == 16'h0055)
				step = 2;
			else if (step == 2 && off == 23'h555 && i_dq == 16'h0088)
			begin
				step = secured ? 3 : 0;
				secured = 1'b1;
			end
			else if (step == 3 && off == 23'h0 && i_dq == 16'h0000)
			begin
				secured = 1'b0;
				step = 0;
			end
			else if (step == 3 && i_pin.addr <= 23'h7f)
			begin
				// A word lands only while both sector locks are open.
				if (persistent_sector_lock && volatile_sector_lock)
					sec[i_pin.addr[6:0]] = i_dq;
				step = 0;
			end
			else
				step = 0;
		end
	end

	// Bench hook for the sector locks. Only a new run, standing in for
	// a power cycle, sets the freeze bit again; no command touches it.
	task automatic set_locks(input logic pers, input logic vol,
		input logic freeze);
		if (persistent_lock_freeze)
			persistent_sector_lock = pers;
		volatile_sector_lock = vol;
		if (!freeze)
			persistent_lock_freeze = 1'b0;
	endtask : set_locks

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	// Released lines show the inverse, so a late sample never matches.
	always @*
	begin
		if (i_ovr)
			word = i_ovr_word;
		else if (secured && i_pin.addr <= 23'h7f)
			word = sec[i_pin.addr[6:0]];
		else
			word = ~i_pin.addr[15:0];
		o_dq = (!i_pin.ce_n && !i_pin.oe_n) ? word : ~word;
	end
endmodule : flash_dev_model

// >>> verification/test_flash_cmd_host.sv
// Self-checking bench for the flash command host.
// Assumes the flash model file and the design package are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
	$display("[ERR] t=%0t got %h exp %h", $time, a, b); n_errors++; end end
module test_flash_cmd_host;
	import flash_host_pkg::*;
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	logic              i_clk = 0;
	logic              i_rstn = 0;
	logic [7:0]        i_addr = 0;
	logic [31:0]       i_wdata = 0;
	logic              i_wr = 0;
	logic              i_rd = 0;
	logic [31:0]       o_rdata;
	flash_pins_type    o_pin;
	logic [DATA_W-1:0] dev_dq;
	logic [DATA_W-1:0] dq_wire;
	logic [DATA_W-1:0] ovr_word = 0;
	logic              ovr = 0;
	logic [ADDR_W-1:0] base = 0;
	logic [31:0]       rd;
	int                n_errors = 0;
	int                n_checks = 0;

	// The wire carries the host's value only while it drives.
	assign dq_wire = o_pin.dq_oe ? o_pin.dq : dev_dq;
	always #50 i_clk = ~i_clk;

	flash_cmd_host flash_cmd_host_i (.i_clk(i_clk), .i_rstn(i_rstn),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .o_pin(o_pin), .i_dq(dq_wire));
	flash_dev_model flash_dev_model_i (.i_pin(o_pin), .i_dq(dq_wire),
		.i_base(base), .i_ovr(ovr), .i_ovr_word(ovr_word), .o_dq(dev_dq));

	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	task automatic results;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : bus_wr

	// Read data stand from the cycle after the strobe until the next read.
	task automatic bus_rd(input logic [7:0] a);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 rd = o_rdata;
	endtask : bus_rd

	task automatic wait_idle;
		for (int k = 0; k < 60; k++)
		begin
			bus_rd(REG_STATUS);
			if (rd[STAT_BUSY] === 1'b0)
				return;
		end
		n_errors++;
		results();
	endtask : wait_idle

	task automatic run_op(input op_type op);
		bus_wr(REG_CMD, {29'h0, op});
		wait_idle();
	endtask : run_op

	// Compares the write cycles that the flash saw since index n0.
	task automatic chk_seq(input int n0, input bus_cycle_type e[$]);
		`CHK(flash_dev_model_i.wn - n0, e.size())
		for (int i = 0; i < e.size(); i++)
		begin
			`CHK(flash_dev_model_i.log_addr[n0 + i], e[i].addr)
			`CHK(flash_dev_model_i.log_data[n0 + i], e[i].data)
		end
	endtask : chk_seq

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_idle;
		`CHK({o_pin.ce_n, o_pin.we_n, o_pin.oe_n, o_pin.dq_oe}, 4'b1110)
		bus_rd(REG_STATUS);
		`CHK(rd, 32'h0)
		bus_rd(8'h20);
		`CHK(rd, 32'h0)
		$display("test idle done");
	endtask : t_idle

	// A non-zero base proves the reset goes to the base region.
	task automatic t_soft_reset;
		int n0;
		base = 23'h400000;
		bus_wr(REG_BASE, {9'h0, base});
		bus_rd(REG_BASE);
		`CHK(rd, 32'h400000)
		n0 = flash_dev_model_i.wn;
		run_op(OP_RESET);
		chk_seq(n0, '{'{23'h400000, 16'h00f0}});
		base = 23'h0;
		bus_wr(REG_BASE, 32'h0);
		$display("test soft reset done");
	endtask : t_soft_reset

	task automatic t_entry;
		int n0;
		n0 = flash_dev_model_i.wn;
		run_op(OP_ENTRY);
		chk_seq(n0, '{'{23'h555, 16'haa}, '{23'h2aa, 16'h55},
			'{23'h555, 16'h88}});
		bus_rd(REG_STATUS);
		`CHK(rd[STAT_SECURED], 1'b1)
		`CHK(flash_dev_model_i.secured, 1'b1)
		$display("test entry done");
	endtask : t_entry

	// Last customer word is accepted, the next address is refused.
	task automatic t_program;
		int n0;
		bus_wr(REG_ADDR, 32'h7f);
		bus_wr(REG_WDATA, 32'h1234);
		n0 = flash_dev_model_i.wn;
		run_op(OP_PROGRAM);
		chk_seq(n0, '{'{23'h555, 16'haa}, '{23'h2aa, 16'h55},
			'{23'h555, 16'h88}, '{23'h7f, 16'h1234}});
		`CHK(flash_dev_model_i.sec[127], 16'h1234)
		bus_wr(REG_ADDR, 32'h80);
		n0 = flash_dev_model_i.wn;
		run_op(OP_PROGRAM);
		`CHK(rd[STAT_DROPPED], 1'b1)
		`CHK(flash_dev_model_i.wn - n0, 0)
		bus_rd(REG_ADDR);
		`CHK(rd, 32'h80)
		bus_rd(REG_WDATA);
		`CHK(rd, 32'h1234)
		$display("test program done");
	endtask : t_program

	// The locks are the flash's own: a closed sector keeps its word.
	task automatic t_protect;
		bus_wr(REG_ADDR, 32'h7e);
		bus_wr(REG_WDATA, 32'hbeef);
		flash_dev_model_i.set_locks(1'b1, 1'b0, 1'b1);
		run_op(OP_PROGRAM);
		`CHK(flash_dev_model_i.sec[126], 16'h5a7e)
		flash_dev_model_i.set_locks(1'b1, 1'b1, 1'b0);
		flash_dev_model_i.set_locks(1'b0, 1'b1, 1'b1);
		`CHK(flash_dev_model_i.persistent_sector_lock, 1'b1)
		run_op(OP_PROGRAM);
		`CHK(flash_dev_model_i.sec[126], 16'hbeef)
		$display("test protect done");
	endtask : t_protect

	// Status and lock bits are tried all set and all clear against the others.
	task automatic t_read;
		logic [15:0] w [2];
		w = '{16'h0027, 16'hffd8};
		bus_wr(REG_ADDR, 32'h3);
		run_op(OP_READ);
		bus_rd(REG_RDATA);
		`CHK(rd[15:0], 16'h5a03)
		for (int i = 0; i < 2; i++)
		begin
			ovr_word = w[i];
			ovr = 1'b1;
			run_op(OP_READ);
			`CHK(rd[STAT_ABORT], w[i][1])
			`CHK(rd[STAT_TIMEOUT], w[i][5])
			`CHK(rd[STAT_LOCK_SECURED], w[i][0])
			`CHK(rd[STAT_LOCK_PERSIST], w[i][1])
			`CHK(rd[STAT_LOCK_PASSWD], w[i][2])
		end
		ovr = 1'b0;
		$display("test read done");
	endtask : t_read

	task automatic t_exit;
		int n0;
		n0 = flash_dev_model_i.wn;
		run_op(OP_EXIT);
		chk_seq(n0, '{'{23'h555, 16'haa}, '{23'h2aa, 16'h55},
			'{23'h555, 16'h88}, '{23'h0, 16'h0}});
		`CHK(rd[STAT_SECURED], 1'b0)
		`CHK(flash_dev_model_i.secured, 1'b0)
		$display("test exit done");
	endtask : t_exit

	// A command back to back with a running one must be dropped.
	task automatic t_reset_abandon;
		int n0;
		n0 = flash_dev_model_i.wn;
		bus_wr(REG_CMD, {29'h0, OP_ENTRY});
		bus_wr(REG_CMD, {29'h0, OP_RESET});
		wait_idle();
		`CHK(rd[STAT_DROPPED], 1'b1)
		`CHK(flash_dev_model_i.wn - n0, 3)
		run_op(OP_RESET);
		`CHK(rd[STAT_SECURED], 1'b0)
		`CHK(flash_dev_model_i.secured, 1'b0)
		`CHK(flash_dev_model_i.persistent_lock_freeze, 1'b0)
		bus_wr(REG_CMD, 32'h6);
		wait_idle();
		`CHK(rd[STAT_DROPPED], 1'b1)
		`CHK(flash_dev_model_i.wn - n0, 4)
		$display("test reset abandon done");
	endtask : t_reset_abandon

	initial
	begin
		repeat (12) @(posedge i_clk);
		i_rstn <= 1'b1;
		@(posedge i_clk);
		t_idle();
		t_soft_reset();
		t_entry();
		t_program();
		t_protect();
		t_read();
		t_exit();
		t_reset_abandon();
		results();
	end
endmodule : test_flash_cmd_host
